// ### rtl/dual_adc_pkg.sv
// How it works
// - Each channel samples on its own clock.
// - Stabiliser regenerates falling edge at half period.
// - Host waits relock time after clock changes.
// - Host enables stabiliser only above rate threshold.
// - Each sleep input stops its own channel.
// - Both asleep switches references off; long wake.
// - Single sleep keeps references; wake in few edges.
// - Host stops clock of sleeping stabilised channel.
// - Output word appears seven sample edges later.
// - Format select low gives offset binary, high twos.
// - Route select high keeps channels on own buses.
// - Route select low swaps the two buses.
// - Route select on sample clock interleaves both.
// - Host holds both sleeps low while interleaving.
// - Host switches unused bus off while interleaving.
// - Host drives shared reference strap when requested.
// - Sense level selects one of four reference modes.
// - Span equals twice the reference voltage.
// - Host divider never runs slower than minimum sample rate; a full FIFO stalls the clock.
package dual_adc_pkg;
  localparam int DATA_W = 14;
  localparam int PIPE_DEPTH = 7;
  localparam int MV_W = 12;
  localparam int CORE_CLK_HZ = 20_000_000;
  localparam int DLL_RELOCK_US = 3;
  localparam int DLL_RELOCK_CYCLES = (DLL_RELOCK_US * CORE_CLK_HZ + 999_999) / 1_000_000;
  localparam int REF_WAKE_MS = 5;
  localparam int REF_WAKE_CYCLES = REF_WAKE_MS * (CORE_CLK_HZ / 1000);
  localparam int CHAN_WAKE_EDGES = 4;
  localparam int STAB_MIN_HZ = 40_000_000;
  localparam int MIN_SAMPLE_HZ = 1_000_000;
  localparam int HOST_HALF_DIV = CORE_CLK_HZ / (2 * MIN_SAMPLE_HZ);
  localparam int MIN_HALF_DIV = 4;
  localparam int LOW_SENSE_MV = 200;
  localparam int FIXED_ONE_MV = 1000;
  localparam int FIXED_HALF_MV = 500;
  localparam int SUPPLY_DETECT_MV = 2000;
  localparam int PERIOD_W = 8;
  localparam int FIFO_W = 16;
  localparam int FIFO_DEPTH = 32;
  typedef enum logic [1:0] {
    REF_FIXED_ONE,
    REF_FIXED_HALF,
    REF_PROGRAMMABLE,
    REF_EXTERNAL
  } ref_mode_t;
endpackage : dual_adc_pkg

// ### rtl/adc_link_if.sv
`timescale 1ns/1ps
// Pins between the converter and the capture logic.
interface adc_link_if;
  logic [1:0] sampleClk;
  logic muxSel;
  logic dutyStabiliserEn;
  logic codeFormatSel;
  logic chanASleep;
  logic chanBSleep;
  logic [1:0] busDriveOffN;
  logic sharedRefEn;
  logic [1:0][dual_adc_pkg::DATA_W-1:0] busData;
  logic [1:0] busOe;

  // The converter end drives the buses and their enables.
  modport dev (
    input sampleClk,
    input muxSel,
    input dutyStabiliserEn,
    input codeFormatSel,
    input chanASleep,
    input chanBSleep,
    input busDriveOffN,
    input sharedRefEn,
    output busData,
    output busOe
  );

  // The capture end drives clocks and straps.
  modport host (
    output sampleClk,
    output muxSel,
    output dutyStabiliserEn,
    output codeFormatSel,
    output chanASleep,
    output chanBSleep,
    output busDriveOffN,
    output sharedRefEn,
    input busData,
    input busOe
  );
endinterface : adc_link_if

// ### rtl/dual_adc_device.sv
`timescale 1ns/1ps
// Digital control and output logic of the dual converter.
module dual_adc_device #(
  parameter int REF_WAKE_CYCLES = dual_adc_pkg::REF_WAKE_CYCLES,
  parameter int SUPPLY_DETECT_MV = dual_adc_pkg::SUPPLY_DETECT_MV
) (
  input wire logic core_clk,
  input wire logic reset_n,
  adc_link_if.dev link,
  input wire logic [dual_adc_pkg::DATA_W-1:0] analogA,
  input wire logic [dual_adc_pkg::DATA_W-1:0] analogB,
  input wire logic [dual_adc_pkg::MV_W-1:0] senseMv,
  input wire logic [dual_adc_pkg::MV_W-1:0] refPinMv,
  output logic [1:0] chanActive,
  output logic [1:0] dutyClk,
  output logic [1:0] dllLocked,
  output logic refPowered,
  output logic sharedRefActive,
  output dual_adc_pkg::ref_mode_t refMode,
  output logic [dual_adc_pkg::MV_W:0] spanMv
);
  localparam int DW = dual_adc_pkg::DATA_W;
  localparam int PD = dual_adc_pkg::PIPE_DEPTH;
  localparam int PW = dual_adc_pkg::PERIOD_W;
  localparam int MW = dual_adc_pkg::MV_W;
  localparam int LW = $clog2(dual_adc_pkg::DLL_RELOCK_CYCLES + 1);
  localparam int WW = $clog2(dual_adc_pkg::CHAN_WAKE_EDGES + 1);
  localparam int RW = $clog2(REF_WAKE_CYCLES + 1);

  typedef struct packed {
    logic clkPrev;
    logic [PD-1:0][DW-1:0] pipe;
    logic [DW-1:0] word;
    logic [PW-1:0] periodCnt;
    logic [PW-1:0] period;
    logic [PW-1:0] phaseCnt;
    logic dutyClk;
    logic [LW-1:0] lockCnt;
    logic locked;
    logic [WW-1:0] wakeCnt;
    logic active;
  } chan_t;

  typedef struct packed {
    chan_t [1:0] ch;
    logic [RW-1:0] refWakeCnt;
    logic [1:0][DW-1:0] busData;
    logic [1:0] busOe;
    logic refPowered;
    logic sharedRef;
    dual_adc_pkg::ref_mode_t refMode;
    logic [MW:0] span;
  } state_t;

  state_t s_reg;
  state_t s_next;
  logic [1:0] rise;
  logic [1:0] sleepReq;
  logic [1:0][DW-1:0] sampleIn;
  logic [1:0][DW-1:0] chanWord;
  logic bothSleep;
  logic [MW-1:0] vrefMv;
  dual_adc_pkg::ref_mode_t modeSel;

  assign sleepReq = {link.chanBSleep, link.chanASleep};
  assign sampleIn = {analogB, analogA};
  assign bothSleep = link.chanASleep && link.chanBSleep;

  // Per channel edge detect on its own clock and output code conversion.
  generate
    for (genvar c = 0; c < 2; c++)
    begin : g_chan
      assign rise[c] = link.sampleClk[c] && !s_reg.ch[c].clkPrev;
      // Flipping the top bit turns offset binary into twos complement.
      assign chanWord[c] = s_reg.ch[c].word ^ {link.codeFormatSel, {(DW - 1){1'b0}}};
    end
  endgenerate

  // Sense level decides the reference mode and the reference voltage.
  always_comb
  begin
    if (senseMv <= MW'(dual_adc_pkg::LOW_SENSE_MV))
    begin
      modeSel = dual_adc_pkg::REF_FIXED_ONE;
      vrefMv = MW'(dual_adc_pkg::FIXED_ONE_MV);
    end
    else if (senseMv >= MW'(SUPPLY_DETECT_MV))
    begin
      modeSel = dual_adc_pkg::REF_EXTERNAL;
      vrefMv = refPinMv;
    end
    else if (senseMv == refPinMv)
    begin
      modeSel = dual_adc_pkg::REF_FIXED_HALF;
      vrefMv = MW'(dual_adc_pkg::FIXED_HALF_MV);
    end
    else
    begin
      modeSel = dual_adc_pkg::REF_PROGRAMMABLE;
      vrefMv = refPinMv;
    end
  end

  // Next state of references, channels and output buses.
  always_comb
  begin
    s_next = s_reg;
    // Total standby drops the references and restarts their long wake.
    if (bothSleep)
    begin
      s_next.refWakeCnt = RW'(REF_WAKE_CYCLES);
    end
    else if (s_reg.refWakeCnt != '0)
    begin
      s_next.refWakeCnt = s_reg.refWakeCnt - 1'b1;
    end
    s_next.refPowered = !bothSleep && (s_reg.refWakeCnt == '0);
    for (int c = 0; c < 2; c++)
    begin
      s_next.ch[c].clkPrev = link.sampleClk[c];
      // Period of the incoming clock measured in core cycles.
      if (rise[c])
      begin
        s_next.ch[c].periodCnt = PW'(1);
        s_next.ch[c].period = s_reg.ch[c].periodCnt;
        s_next.ch[c].phaseCnt = PW'(1);
        if (s_reg.ch[c].periodCnt != s_reg.ch[c].period)
        begin
          s_next.ch[c].lockCnt = LW'(dual_adc_pkg::DLL_RELOCK_CYCLES);
        end
      end
      else
      begin
        if (s_reg.ch[c].periodCnt != '1)
        begin
          s_next.ch[c].periodCnt = s_reg.ch[c].periodCnt + 1'b1;
        end
        if (s_reg.ch[c].phaseCnt != '1)
        begin
          s_next.ch[c].phaseCnt = s_reg.ch[c].phaseCnt + 1'b1;
        end
      end
      // With the stabiliser on the falling edge is placed at half period.
      if (link.dutyStabiliserEn)
      begin
        if (rise[c])
        begin
          s_next.ch[c].dutyClk = 1'b1;
        end
        else if (s_reg.ch[c].phaseCnt >= (s_reg.ch[c].period >> 1))
        begin
          s_next.ch[c].dutyClk = 1'b0;
        end
        if (!rise[c] && s_reg.ch[c].lockCnt != '0)
        begin
          s_next.ch[c].lockCnt = s_reg.ch[c].lockCnt - 1'b1;
        end
      end
      else
      begin
        s_next.ch[c].dutyClk = link.sampleClk[c];
        s_next.ch[c].lockCnt = LW'(dual_adc_pkg::DLL_RELOCK_CYCLES);
      end
      // The lock flag is registered so that the output comes from a flop.
      s_next.ch[c].locked = (s_next.ch[c].lockCnt == '0);
      // A sleeping channel stops; waking waits for the references.
      if (sleepReq[c])
      begin
        s_next.ch[c].active = 1'b0;
        s_next.ch[c].wakeCnt = WW'(dual_adc_pkg::CHAN_WAKE_EDGES);
      end
      else if (bothSleep || s_reg.refWakeCnt != '0)
      begin
        s_next.ch[c].active = 1'b0;
      end
      else if (s_reg.ch[c].wakeCnt != '0)
      begin
        if (rise[c])
        begin
          s_next.ch[c].wakeCnt = s_reg.ch[c].wakeCnt - 1'b1;
        end
      end
      else
      begin
        s_next.ch[c].active = 1'b1;
      end
      // Seven stage pipeline then the output latch, all on the sample edge.
      if (rise[c] && s_reg.ch[c].active)
      begin
        s_next.ch[c].pipe[0] = sampleIn[c];
        for (int i = 1; i < PD; i++)
        begin
          s_next.ch[c].pipe[i] = s_reg.ch[c].pipe[i - 1];
        end
        s_next.ch[c].word = s_reg.ch[c].pipe[PD - 1];
      end
    end
    // Route select picks straight or swapped buses; it may toggle each edge.
    if (link.muxSel)
    begin
      s_next.busData[0] = chanWord[0];
      s_next.busData[1] = chanWord[1];
    end
    else
    begin
      s_next.busData[0] = chanWord[1];
      s_next.busData[1] = chanWord[0];
    end
    s_next.busOe = ~link.busDriveOffN;
    s_next.sharedRef = link.sharedRefEn;
    s_next.refMode = modeSel;
    s_next.span = {vrefMv, 1'b0};
  end

  // State register with synchronous reset.
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // Every output comes from the state register.
  assign link.busData = s_reg.busData;
  assign link.busOe = s_reg.busOe;
  assign chanActive = {s_reg.ch[1].active, s_reg.ch[0].active};
  assign dutyClk = {s_reg.ch[1].dutyClk, s_reg.ch[0].dutyClk};
  assign dllLocked = {s_reg.ch[1].locked, s_reg.ch[0].locked};
  assign refPowered = s_reg.refPowered;
  assign sharedRefActive = s_reg.sharedRef;
  assign refMode = s_reg.refMode;
  assign spanMv = s_reg.span;
endmodule : dual_adc_device

// ### rtl/adc_capture_host.sv
`timescale 1ns/1ps
// Word FIFO with a registered output stage.
module sample_fifo #(
  parameter int WIDTH = dual_adc_pkg::FIFO_W,
  parameter int DEPTH = dual_adc_pkg::FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
    logic outValid;
    logic [WIDTH-1:0] outData;
  } fifo_t;

  fifo_t s_reg;
  fifo_t s_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic load;

  assign inReady = s_reg.count != (AW + 1)'(DEPTH);
  assign push = inValid && inReady;
  assign load = (s_reg.count != '0) && (!s_reg.outValid || outReady);

  // Pointers advance on push and on refill of the output stage.
  always_comb
  begin
    s_next = s_reg;
    if (push)
    begin
      s_next.wrPtr = s_reg.wrPtr + 1'b1;
    end
    if (load)
    begin
      s_next.rdPtr = s_reg.rdPtr + 1'b1;
      s_next.outData = mem[s_reg.rdPtr];
      s_next.outValid = 1'b1;
    end
    else if (outReady)
    begin
      s_next.outValid = 1'b0;
    end
    s_next.count = s_reg.count + (AW + 1)'(push) - (AW + 1)'(load);
  end

  // State register and storage array.
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
    if (push)
    begin
      mem[s_reg.wrPtr] <= inData;
    end
  end

  assign outValid = s_reg.outValid;
  assign outData = s_reg.outData;
endmodule : sample_fifo

// Capture logic: makes the sample clock, drives straps, buffers words.
module adc_capture_host #(
  parameter int HALF_DIV = dual_adc_pkg::HOST_HALF_DIV
) (
  input wire logic core_clk,
  input wire logic reset_n,
  adc_link_if.host link,
  input wire logic cfgInterleave,
  input wire logic cfgStabiliser,
  input wire logic cfgTwosComp,
  input wire logic cfgSleepA,
  input wire logic cfgSleepB,
  input wire logic cfgSharedRef,
  input wire logic captureEn,
  output logic outValid,
  output logic [dual_adc_pkg::FIFO_W-1:0] outData,
  input wire logic outReady,
  output logic stabiliserActive,
  output logic settling
);
  localparam int DW = dual_adc_pkg::DATA_W;
  localparam int FW = dual_adc_pkg::FIFO_W;
  // The half period is clamped so the rate never falls below the minimum.
  localparam int HALF_LIM = (HALF_DIV > dual_adc_pkg::HOST_HALF_DIV) ?
    dual_adc_pkg::HOST_HALF_DIV : HALF_DIV;
  localparam int HALF = (HALF_LIM < dual_adc_pkg::MIN_HALF_DIV) ?
    dual_adc_pkg::MIN_HALF_DIV : HALF_LIM;
  localparam int SAMPLE_HZ = dual_adc_pkg::CORE_CLK_HZ / (2 * HALF);
  localparam bit STAB_OK = SAMPLE_HZ > dual_adc_pkg::STAB_MIN_HZ;
  localparam int CW = $clog2(HALF + 1);
  localparam int SW = $clog2(dual_adc_pkg::DLL_RELOCK_CYCLES + 1);

  typedef struct packed {
    logic clk;
    logic [CW-1:0] phaseCnt;
    logic [1:0] sampleClk;
    logic muxSel;
    logic stabEn;
    logic fmt;
    logic sleepA;
    logic sleepB;
    logic [1:0] driveOffN;
    logic sharedRef;
    logic interleave;
    logic [SW-1:0] settleCnt;
    logic settling;
  } host_t;

  host_t s_reg;
  host_t s_next;
  logic pushWant;
  logic [FW-1:0] pushData;
  logic fifoReady;
  logic lastPh;
  logic preLast;

  assign lastPh = s_reg.phaseCnt == CW'(HALF - 1);
  assign preLast = s_reg.phaseCnt == CW'(HALF - 2);

  // Push points sit late in each half period when interleaving, else late in the high half only, when the bus has settled.
  always_comb
  begin
    pushWant = 1'b0;
    pushData = '0;
    if (captureEn && s_reg.settleCnt == '0)
    begin
      if (s_reg.interleave)
      begin
        // Bus A carries channel A in the high half, channel B in the low.
        pushWant = lastPh;
        pushData = {!s_reg.clk, {(FW - DW - 1){1'b0}}, link.busData[0]};
      end
      else if (s_reg.clk && preLast && !s_reg.sleepA)
      begin
        pushWant = 1'b1;
        pushData = {1'b0, {(FW - DW - 1){1'b0}}, link.busData[0]};
      end
      else if (s_reg.clk && lastPh && !s_reg.sleepB)
      begin
        pushWant = 1'b1;
        pushData = {1'b1, {(FW - DW - 1){1'b0}}, link.busData[1]};
      end
    end
  end

  // Next state of the clock divider and the pins.
  always_comb
  begin
    s_next = s_reg;
    s_next.stabEn = cfgStabiliser && STAB_OK;
    s_next.sleepA = cfgSleepA && !cfgInterleave;
    s_next.sleepB = cfgSleepB && !cfgInterleave;
    s_next.fmt = cfgTwosComp;
    s_next.sharedRef = cfgSharedRef;
    s_next.interleave = cfgInterleave;
    s_next.driveOffN = {cfgInterleave, 1'b0};
    // Any change of the delivered clocks restarts the settle wait.
    if (s_next.stabEn != s_reg.stabEn || s_next.sleepA != s_reg.sleepA ||
        s_next.sleepB != s_reg.sleepB || s_next.interleave != s_reg.interleave)
    begin
      s_next.settleCnt = SW'(dual_adc_pkg::DLL_RELOCK_CYCLES);
    end
    else if (s_reg.settleCnt != '0)
    begin
      s_next.settleCnt = s_reg.settleCnt - 1'b1;
    end
    // The settle flag is registered so that the output comes from a flop.
    s_next.settling = (s_next.settleCnt != '0);
    // A full FIFO holds the divider, which stalls the sample clock.
    if (!(pushWant && !fifoReady))
    begin
      if (lastPh)
      begin
        s_next.phaseCnt = '0;
        s_next.clk = !s_reg.clk;
      end
      else
      begin
        s_next.phaseCnt = s_reg.phaseCnt + 1'b1;
      end
    end
    s_next.sampleClk[0] = s_next.clk && !(s_next.stabEn && s_next.sleepA);
    s_next.sampleClk[1] = s_next.clk && !(s_next.stabEn && s_next.sleepB);
    s_next.muxSel = s_next.interleave ? s_next.clk : 1'b1;
  end

  // State register with synchronous reset.
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  sample_fifo #(
    .WIDTH(FW),
    .DEPTH(dual_adc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .inValid(pushWant),
    .inData(pushData),
    .inReady(fifoReady),
    .outValid(outValid),
    .outData(outData),
    .outReady(outReady)
  );

  assign link.sampleClk = s_reg.sampleClk;
  assign link.muxSel = s_reg.muxSel;
  assign link.dutyStabiliserEn = s_reg.stabEn;
  assign link.codeFormatSel = s_reg.fmt;
  assign link.chanASleep = s_reg.sleepA;
  assign link.chanBSleep = s_reg.sleepB;
  assign link.busDriveOffN = s_reg.driveOffN;
  assign link.sharedRefEn = s_reg.sharedRef;
  assign stabiliserActive = s_reg.stabEn;
  assign settling = s_reg.settling;
endmodule : adc_capture_host

// ### sim/dual_adc_asserts.sv
`timescale 1ns/1ps
// Watches the pins between the converter end and the capture end.
module dual_adc_asserts (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [1:0] sampleClk,
  input wire logic muxSel,
  input wire logic codeFormatSel,
  input wire logic chanASleep,
  input wire logic chanBSleep,
  input wire logic [1:0] busDriveOffN,
  input wire logic [1:0][dual_adc_pkg::DATA_W-1:0] busData,
  input wire logic [1:0] busOe
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  // A bus drives only while its drive-off strap is low, one cycle later.
  chk_oe_follows: assert property (
    $past(reset_n) |-> busOe == ~$past(busDriveOffN))
    else $error("bus enable does not follow drive-off strap");
  // With clocks and selects quiet for three cycles no word may move.
  chk_bus_holds: assert property (
    ($stable(sampleClk) && $stable(muxSel) && $stable(codeFormatSel))[*3] |-> $stable(busData))
    else $error("bus word moved without a cause");
  // A select change swaps the two words on the next cycle.
  chk_mux_swap: assert property (
    $changed(muxSel) && $stable(codeFormatSel) && $past(sampleClk) == $past(sampleClk, 2)
    |=> busData == {$past(busData[0]), $past(busData[1])})
    else $error("bus swap did not follow select");
  // A format change flips only the top bit of both words.
  chk_format_flip: assert property (
    $changed(codeFormatSel) && $stable(muxSel) && $past(sampleClk) == $past(sampleClk, 2)
    |=> busData == ($past(busData) ^ {2{14'h2000}}))
    else $error("format change did not flip the top bit");
  // A sleeping channel freezes its word.
  chk_sleep_a_freeze: assert property (
    (chanASleep && muxSel && $stable(muxSel) && $stable(codeFormatSel))[*5]
    |-> $stable(busData[0]))
    else $error("sleeping channel A word moved");
  chk_sleep_b_freeze: assert property (
    (chanBSleep && muxSel && $stable(muxSel) && $stable(codeFormatSel))[*5]
    |-> $stable(busData[1]))
    else $error("sleeping channel B word moved");
  // Select is only low while interleaving: both awake, unused bus off.
  chk_mux_awake: assert property (
    $past(reset_n) && !muxSel |-> !chanASleep && !chanBSleep)
    else $error("channel asleep while interleaving");
  chk_unused_off: assert property (
    $past(reset_n) && !muxSel |-> busDriveOffN == 2'b10)
    else $error("unused bus left on while interleaving");

  // Main scenarios.
  cov_interleave: cover property ($rose(muxSel) && $rose(sampleClk[0]));
  cov_format: cover property ($changed(codeFormatSel));
  cov_sleep: cover property (chanASleep && chanBSleep);
endmodule : dual_adc_asserts

// ### sim/tb.sv
`timescale 1ns/1ps
// Self-checking bench joining the converter end and the capture end.
module tb;
  localparam int WAKE = 50;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [13:0] analogA = 14'h0000;
  logic [13:0] analogB = 14'h0000;
  logic [11:0] senseMv = 12'h000;
  logic [11:0] refPinMv = 12'h000;
  logic cfgInterleave = 1'b0;
  logic cfgStabiliser = 1'b0;
  logic cfgTwosComp = 1'b0;
  logic cfgSleepA = 1'b0;
  logic cfgSleepB = 1'b0;
  logic cfgSharedRef = 1'b0;
  logic captureEn = 1'b0;
  logic outReady = 1'b1;
  logic outValid;
  logic [15:0] outData;
  logic stabiliserActive;
  logic settling;
  logic [1:0] chanActive;
  logic [1:0] dutyClk;
  logic [1:0] dllLocked;
  logic refPowered;
  logic sharedRefActive;
  dual_adc_pkg::ref_mode_t refMode;
  logic [12:0] spanMv;
  logic [1:0] clkSeen = 2'b00;
  logic [13:0] smpA[$];
  logic [13:0] smpB[$];
  int lastIdx = 0;
  int popA = 0;
  int popB = 0;
  bit chkEn = 1'b0;
  int miscompares = 0;
  int comparisons = 0;

  adc_link_if u_adc_link_if ();
  dual_adc_device #(.REF_WAKE_CYCLES(WAKE), .SUPPLY_DETECT_MV(dual_adc_pkg::SUPPLY_DETECT_MV))
    u_dual_adc_device (.core_clk(core_clk), .reset_n(reset_n), .link(u_adc_link_if),
    .analogA(analogA), .analogB(analogB), .senseMv(senseMv), .refPinMv(refPinMv),
    .chanActive(chanActive), .dutyClk(dutyClk), .dllLocked(dllLocked), .refPowered(refPowered),
    .sharedRefActive(sharedRefActive), .refMode(refMode), .spanMv(spanMv));
  adc_capture_host u_adc_capture_host (.core_clk(core_clk), .reset_n(reset_n),
    .link(u_adc_link_if), .cfgInterleave(cfgInterleave), .cfgStabiliser(cfgStabiliser),
    .cfgTwosComp(cfgTwosComp), .cfgSleepA(cfgSleepA), .cfgSleepB(cfgSleepB),
    .cfgSharedRef(cfgSharedRef), .captureEn(captureEn), .outValid(outValid),
    .outData(outData), .outReady(outReady), .stabiliserActive(stabiliserActive),
    .settling(settling));
  dual_adc_asserts u_dual_adc_asserts (.core_clk(core_clk), .reset_n(reset_n),
    .sampleClk(u_adc_link_if.sampleClk), .muxSel(u_adc_link_if.muxSel),
    .codeFormatSel(u_adc_link_if.codeFormatSel), .chanASleep(u_adc_link_if.chanASleep),
    .chanBSleep(u_adc_link_if.chanBSleep), .busDriveOffN(u_adc_link_if.busDriveOffN),
    .busData(u_adc_link_if.busData), .busOe(u_adc_link_if.busOe));

  // The clock runs at 20 MHz.
  initial
  begin
    forever #25 core_clk = ~core_clk;
  end

  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Prints the counts and the verdict, then stops.
  task automatic end_of_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  // Expected capture word: channel tag, zero bit, then the formatted sample.
  function automatic logic [15:0] expWord(input logic tag, input logic [13:0] v,
                                          input logic twos);
    return {tag, 1'b0, v ^ {twos, 13'h0000}};
  endfunction : expWord

  task automatic waitRises(input int n);
    repeat (n) @(posedge u_adc_link_if.sampleClk[0]);
    @(negedge core_clk);
  endtask : waitRises

  // Records samples at each rise, changes inputs in the low half, checks popped words.
  always @(negedge core_clk)
  begin
    if (u_adc_link_if.sampleClk[0] && !clkSeen[0])
    begin
      smpA.push_back(analogA);
      smpB.push_back(analogB);
    end
    if (!u_adc_link_if.sampleClk[0] && clkSeen[0])
    begin
      analogA <= 14'($urandom);
      analogB <= 14'($urandom);
    end
    // Stabiliser off: the internal clock trails the pin by one cycle, never locked.
    if (chkEn)
      check({12'h000, dllLocked, dutyClk}, {14'h0000, clkSeen});
    clkSeen <= u_adc_link_if.sampleClk;
    if (outValid === 1'b1 && outReady)
    begin
      if (outData[15])
        popB++;
      else
        popA++;
      if (chkEn && !outData[15])
        lastIdx = smpA.size() - 8;
      if (chkEn)
        check(outData, expWord(outData[15], outData[15] ? smpB[lastIdx] : smpA[lastIdx],
                               cfgTwosComp));
    end
  end

  // Cuts a hang short.
  initial
  begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    end_of_test();
  end

  // Main sequence of tests.
  initial
  begin
    int a0;
    int n;
    logic [11:0] r;
    logic [11:0] s;
    logic [14:0] e;
    void'($urandom(32'h0000_02cf));
    repeat (2) @(negedge core_clk);
    reset_n = 1'b1;
    captureEn = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      cfgInterleave = i[1];
      cfgTwosComp = i[0];
      waitRises(8);
      repeat (3) @(negedge core_clk);
      chkEn = 1'b1;
      waitRises(16);
      chkEn = 1'b0;
      check({13'h0000, settling, u_adc_link_if.busOe}, {14'h0000, i[1] ? 2'b01 : 2'b11});
      $display("test capture mode %0d done", i);
    end
    cfgInterleave = 1'b0;
    cfgSleepA = 1'b1;
    @(negedge core_clk);
    check({15'h0000, settling}, 16'h0001);
    waitRises(6);
    a0 = popA;
    n = popB;
    waitRises(6);
    check(16'(popA - a0), 16'h0000);
    check({14'h0000, popB > n, chanActive[0]}, 16'h0002);
    check({15'h0000, refPowered}, 16'h0001);
    cfgSleepA = 1'b0;
    waitRises(6);
    check({14'h0000, chanActive}, 16'h0003);
    $display("test single sleep done");
    cfgSleepA = 1'b1;
    cfgSleepB = 1'b1;
    waitRises(3);
    check({15'h0000, refPowered}, 16'h0000);
    cfgSleepA = 1'b0;
    cfgSleepB = 1'b0;
    repeat (40) @(negedge core_clk);
    check({14'h0000, chanActive}, 16'h0000);
    for (n = 0; n < 200 && chanActive !== 2'b11; n++)
      @(negedge core_clk);
    check({14'h0000, chanActive}, 16'h0003);
    $display("test full sleep done");
    cfgSharedRef = 1'b1;
    cfgStabiliser = 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      r = 12'($urandom_range(300, 1900));
      s = (i == 0) ? 12'h000 : (i == 1) ? 12'h0c8 : (i == 2) ? 12'h7d0 : (i == 3) ? r : 12'h0c9;
      e = (i < 2) ? {dual_adc_pkg::REF_FIXED_ONE, 13'h07d0} :
          (i == 2) ? {dual_adc_pkg::REF_EXTERNAL, {r, 1'b0}} :
          (i == 3) ? {dual_adc_pkg::REF_FIXED_HALF, 13'h03e8} :
          {dual_adc_pkg::REF_PROGRAMMABLE, {r, 1'b0}};
      senseMv = s;
      refPinMv = r;
      repeat (3) @(negedge core_clk);
      check({1'b0, refMode, spanMv}, {1'b0, e});
    end
    check({13'h0000, sharedRefActive, u_adc_link_if.dutyStabiliserEn, stabiliserActive},
          16'h0004);
    $display("test reference done");
    outReady = 1'b0;
    repeat (900) @(negedge core_clk);
    n = smpA.size();
    repeat (100) @(negedge core_clk);
    check({15'h0000, outValid}, 16'h0001);
    check(16'(smpA.size() - n), 16'h0000);
    captureEn = 1'b0;
    a0 = popA + popB;
    outReady = 1'b1;
    repeat (60) @(negedge core_clk);
    n = popA + popB - a0;
    check({14'h0000, outValid, n >= 32 && n <= 33}, 16'h0001);
    $display("test buffer fill and drain done");
    end_of_test();
  end
endmodule : tb
